// ==== shared/rst_pkg.sv ====
// reset initialization sequencer: shared constants and carrier types
// assumes one core clock at 40 MHz standing in for the pci sync clock period
//
// Summary of operation
// R1 - a hard or soft reset input starts a flow only if held low for at least 32 sync periods.
// R2 - in host mode the board holds power-on reset low 32 input-clock periods on a stable clock.
// R3 - in agent mode the board holds power-on reset low 32 periods of a stable sync clock.
// R4 - when the device drives hard and soft reset it holds them low at least 512 sync periods.
// R5 - soft reset is released no sooner than 16 sync periods after hard reset is released.
// R6 - the board presents reset-source and clock-divide strap values 4 periods before release.
// R7 - the board keeps the strap values valid until hard reset has been released.
// R8 - the device stops driving the strap pins at hard reset and drives them 1 period after release.
// R9 - in host mode the sync period is derived from the input clock by the sampled divide strap.
// R10 - the device only pulls the reset pins low and leaves them undriven when released.
// R11 - reset inputs pass a two-flop synchroniser before their length is counted.
package rst_pkg;

  // ----------------------------------------------------------------
  // timing counts, in sync periods
  // ----------------------------------------------------------------
  localparam int unsigned MIN_IN_ASSERT   = 32;
  localparam int unsigned MIN_OUT_ASSERT  = 512;
  localparam int unsigned HARD_TO_SOFT    = 16;
  localparam int unsigned CFG_REDRIVE_DLY = 1;
  localparam int unsigned CNT_W           = 10;

  localparam logic [CNT_W-1:0] IN_CNT_MAX  = CNT_W'(MIN_IN_ASSERT - 1);
  // one extra tick: the first sync period after entry may be only partly seen
  localparam logic [CNT_W-1:0] OUT_CNT_MAX = CNT_W'(MIN_OUT_ASSERT);
  localparam logic [CNT_W-1:0] H2S_CNT_MAX = CNT_W'(HARD_TO_SOFT - 1);
  localparam logic [CNT_W-1:0] RDV_CNT_MAX = CNT_W'(CFG_REDRIVE_DLY - 1);

  // ----------------------------------------------------------------
  // strap layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SRC_W           = 3;
  localparam logic [SRC_W-1:0] SRC_RST    = 3'h0;
  localparam logic             DIV_RST    = 1'h0;

  typedef struct packed {
    logic [SRC_W-1:0] reset_source;
    logic             input_clock_divide_cfg;
  } rst_cfg_t;

  // open-drain pin: input, output, enable
  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } rst_od_t;

  typedef enum logic [2:0] {
    ST_POR   = 3'h0,
    ST_RUN   = 3'h1,
    ST_HARD  = 3'h2,
    ST_SOFT  = 3'h3,
    ST_H2S   = 3'h4,
    ST_WAITH = 3'h5,
    ST_WAITS = 3'h6
  } rst_state_t;

endpackage

// ==== hw/rst_len_filter.sv ====
// reset input length filter: synchroniser plus low-time counter
// assumes the pin is asynchronous to core_clk_i and the tick is a one-cycle enable
`timescale 1ns/1ps
module rst_len_filter
  import rst_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic tick_i,
  input  wire logic pin_n_i,
  output logic      low_o,
  output logic      qual_o
);

  logic             sync1_q;
  logic             sync2_q;
  logic [CNT_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sync1_q <= 1'h1;
      sync2_q <= 1'h1;
    end else begin
      sync1_q <= pin_n_i; // R11
      sync2_q <= sync1_q; // R11
    end
  end

  assign low_o = ~sync2_q;

  // ----------------------------------------------------------------
  // length counter, counts sync periods while low
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || sync2_q) begin
      cnt_q  <= '0;
      qual_o <= 1'h0;
    end else if (tick_i) begin
      if (cnt_q == IN_CNT_MAX) begin
        qual_o <= 1'h1; // R1
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

endmodule

// ==== hw/rst_seq.sv ====
// reset initialization sequencer top
// assumes power-on reset input already meets its length on a stable clock;
// in host mode the sync period comes from core clock divided per the sampled divide strap
`timescale 1ns/1ps
module rst_seq
  import rst_pkg::*;
(
  input  wire logic     core_clk_i,
  input  wire logic     resetn_i,
  input  wire logic     host_mode_i,
  input  wire logic     power_on_reset_in_n_i,
  input  wire logic     hard_reset_line_n_i,
  input  wire logic     soft_reset_line_n_i,
  input  wire logic     sw_hard_req_i,
  input  wire rst_cfg_t cfg_pins_i,
  input  wire rst_cfg_t cfg_drive_val_i,
  output logic          hard_reset_line_o,
  output logic          hard_reset_line_oe_o,
  output logic          soft_reset_line_o,
  output logic          soft_reset_line_oe_o,
  output rst_cfg_t      cfg_pins_o,
  output logic          cfg_pins_oe_o,
  output rst_cfg_t      cfg_latched_o,
  output logic          core_hard_rst_n_o,
  output logic          core_soft_rst_n_o
);

  rst_state_t       state_q;
  logic [CNT_W-1:0] cnt_q;
  logic             por_s1_q;
  logic             por_s2_q;
  logic             por_prev_q;
  rst_cfg_t         cfg_s1_q;
  rst_cfg_t         cfg_s2_q;
  logic             div_q;
  logic             tick_q;
  logic             hard_low;
  logic             soft_low;
  logic             hard_qual;
  logic             soft_qual;
  logic [CNT_W-1:0] rdv_q;
  logic             rdv_arm_q;

  // ----------------------------------------------------------------
  // sync period enable
  // ----------------------------------------------------------------
  // divide strap 1 in host mode halves the rate; agent mode ticks every cycle
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      div_q  <= 1'h0;
      tick_q <= 1'h0;
    end else if (host_mode_i && cfg_latched_o.input_clock_divide_cfg) begin
      div_q  <= ~div_q; // R9
      tick_q <= div_q;  // R9
    end else begin
      div_q  <= 1'h0;
      tick_q <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      por_s1_q   <= 1'h0;
      por_s2_q   <= 1'h0;
      por_prev_q <= 1'h0;
      cfg_s1_q   <= '0;
      cfg_s2_q   <= '0;
    end else begin
      por_s1_q   <= power_on_reset_in_n_i;
      por_s2_q   <= por_s1_q;
      por_prev_q <= por_s2_q;
      cfg_s1_q   <= cfg_pins_i;
      cfg_s2_q   <= cfg_s1_q;
    end
  end

  rst_len_filter u_hard_flt (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .tick_i     (tick_q),
    .pin_n_i    (hard_reset_line_n_i),
    .low_o      (hard_low),
    .qual_o     (hard_qual)
  );

  rst_len_filter u_soft_flt (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .tick_i     (tick_q),
    .pin_n_i    (soft_reset_line_n_i),
    .low_o      (soft_low),
    .qual_o     (soft_qual)
  );

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // captured on the rising edge of the synchronised power-on reset;
  // board setup margin covers the two-flop delay
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cfg_latched_o <= '{reset_source: SRC_RST, input_clock_divide_cfg: DIV_RST};
    end else if (por_s2_q && !por_prev_q) begin
      cfg_latched_o <= cfg_s2_q; // R6
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !por_s2_q) begin
      state_q <= ST_POR;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_POR: begin
          state_q <= ST_HARD;
          cnt_q   <= '0;
        end
        ST_RUN: begin
          cnt_q <= '0;
          if (hard_qual || sw_hard_req_i) begin
            state_q <= ST_HARD; // R1
          end else if (soft_qual) begin
            state_q <= ST_SOFT; // R1
          end
        end
        ST_HARD: begin
          if (tick_q) begin
            if (cnt_q == OUT_CNT_MAX) begin
              state_q <= ST_H2S; // R4
              cnt_q   <= '0;
            end else begin
              cnt_q <= cnt_q + CNT_W'(1);
            end
          end
        end
        ST_H2S: begin
          // wait also for other agents to let go of hard reset
          if (tick_q && !hard_low) begin
            if (cnt_q == H2S_CNT_MAX) begin
              state_q <= ST_WAITS; // R5
            end else begin
              cnt_q <= cnt_q + CNT_W'(1);
            end
          end
        end
        ST_SOFT: begin
          if (tick_q) begin
            if (cnt_q == OUT_CNT_MAX) begin
              state_q <= ST_WAITS; // R4
            end else begin
              cnt_q <= cnt_q + CNT_W'(1);
            end
          end
        end
        ST_WAITS: begin
          if (!soft_low) begin
            state_q <= ST_WAITH;
          end
        end
        ST_WAITH: begin
          if (!hard_low) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_POR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // open-drain reset drivers
  // ----------------------------------------------------------------
  // output data tied low; only the enable moves, so the pin is never driven high
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      hard_reset_line_o    <= 1'h0;
      hard_reset_line_oe_o <= 1'h1;
      soft_reset_line_o    <= 1'h0;
      soft_reset_line_oe_o <= 1'h1;
    end else begin
      hard_reset_line_o    <= 1'h0; // R10
      soft_reset_line_o    <= 1'h0; // R10
      hard_reset_line_oe_o <= (state_q == ST_POR) || (state_q == ST_HARD); // R10
      soft_reset_line_oe_o <= (state_q == ST_POR) || (state_q == ST_HARD) ||
                              (state_q == ST_H2S) || (state_q == ST_SOFT); // R5
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      core_hard_rst_n_o <= 1'h0;
      core_soft_rst_n_o <= 1'h0;
    end else begin
      core_hard_rst_n_o <= !hard_low && (state_q == ST_RUN || state_q == ST_WAITH);
      core_soft_rst_n_o <= !soft_low && !hard_low && (state_q == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // strap pin driver
  // ----------------------------------------------------------------
  // off at once when hard reset is seen low, back on after one sync period of release
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cfg_pins_oe_o <= 1'h0;
      cfg_pins_o    <= '0;
      rdv_q         <= '0;
      rdv_arm_q     <= 1'h0;
    end else begin
      cfg_pins_o <= cfg_drive_val_i;
      if (hard_low || hard_reset_line_oe_o || (state_q == ST_HARD) || !por_s2_q) begin
        cfg_pins_oe_o <= 1'h0; // R8
        rdv_q         <= '0;
        rdv_arm_q     <= 1'h1;
      end else if (rdv_arm_q && tick_q) begin
        if (rdv_q == RDV_CNT_MAX) begin
          rdv_arm_q     <= 1'h0;
          cfg_pins_oe_o <= 1'h1; // R8
        end else begin
          rdv_q <= rdv_q + CNT_W'(1);
        end
      end
    end
  end

endmodule

// ==== verification/rst_board_model.sv ====
// board side: pull-ups, other reset agents, strap resistors
// assumes the bench commands the pulses and the strap word
`timescale 1ns/1ps
module rst_board_model
  import rst_pkg::*;
(
  input  wire logic     core_clk_i,
  input  wire logic     hard_oe_i,
  input  wire logic     soft_oe_i,
  input  wire logic     hard_pull_i,
  input  wire logic     soft_pull_i,
  input  wire rst_cfg_t strap_i,
  input  wire rst_cfg_t dut_cfg_i,
  input  wire logic     dut_cfg_oe_i,
  output logic          hard_n_o,
  output logic          soft_n_o,
  output rst_cfg_t      cfg_o
);
  logic strap_on_q = 1'b1;
  // wired low: any puller wins, pull-up otherwise
  assign hard_n_o = !(hard_oe_i || hard_pull_i);
  assign soft_n_o = !(soft_oe_i || soft_pull_i);
  // straps held while hard reset is low, released after
  always_ff @(posedge core_clk_i) begin
    strap_on_q <= !hard_n_o;
  end
  // released straps show the inverse, never the old word
  assign cfg_o = dut_cfg_oe_i ? dut_cfg_i : (strap_on_q ? strap_i : ~strap_i);
endmodule

// ==== verification/rst_seq_assertions.sv ====
// checker on the reset sequencer top ports
// assumes bind to rst_seq; helper counters saturate
`timescale 1ns/1ps
module rst_seq_assertions
  import rst_pkg::*;
(
  input wire logic     core_clk_i,
  input wire logic     resetn_i,
  input wire logic     host_mode_i,
  input wire logic     power_on_reset_in_n_i,
  input wire logic     hard_reset_line_n_i,
  input wire logic     soft_reset_line_n_i,
  input wire logic     sw_hard_req_i,
  input wire logic     hard_reset_line_o,
  input wire logic     hard_reset_line_oe_o,
  input wire logic     soft_reset_line_o,
  input wire logic     soft_reset_line_oe_o,
  input wire logic     cfg_pins_oe_o,
  input wire rst_cfg_t cfg_latched_o,
  input wire logic     core_hard_rst_n_o,
  input wire logic     core_soft_rst_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [10:0] hon_q;
  logic [10:0] son_q;
  logic [10:0] hoff_q;
  logic [10:0] plow_q;
  logic [10:0] slow_q;
  logic [10:0] plast_q;
  logic [10:0] slast_q;
  logic        div_mode;
  // ----------------------------------------------------------------
  // run lengths
  // ----------------------------------------------------------------
  assign div_mode = host_mode_i && cfg_latched_o.input_clock_divide_cfg;
  // cleared in reset so unknown outputs before reset never reach a counter
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      hon_q  <= '0;
      son_q  <= '0;
      hoff_q <= '0;
    end else begin
      hon_q  <= !hard_reset_line_oe_o ? '0 : hon_q + {10'h0, ~&hon_q};
      son_q  <= !soft_reset_line_oe_o ? '0 : son_q + {10'h0, ~&son_q};
      hoff_q <= hard_reset_line_oe_o ? '0 : hoff_q + {10'h0, ~&hoff_q};
    end
  end
  // last finished low run kept: a flow may start after a qualifying pulse is released
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      plow_q  <= '0;
      slow_q  <= '0;
      plast_q <= '0;
      slast_q <= '0;
    end else begin
      plow_q <= hard_reset_line_n_i ? '0 : plow_q + {10'h0, ~&plow_q};
      slow_q <= soft_reset_line_n_i ? '0 : slow_q + {10'h0, ~&slow_q};
      if (hard_reset_line_n_i && plow_q != '0) begin
        plast_q <= plow_q;
      end
      if (soft_reset_line_n_i && slow_q != '0) begin
        slast_q <= slow_q;
      end
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_hard_len: assert property ($fell(hard_reset_line_oe_o) |-> hon_q >=
    (div_mode ? 1024 : 512))
    else $error("hard pull too short");
  a_soft_len: assert property ($fell(soft_reset_line_oe_o) |-> son_q >=
    (div_mode ? 1024 : 512))
    else $error("soft pull too short");
  a_soft_gap: assert property ($fell(soft_reset_line_oe_o) |->
    hoff_q >= (div_mode ? 32 : 16))
    else $error("soft released too soon");
  a_od_data: assert property (!hard_reset_line_o && !soft_reset_line_o)
    else $error("reset pin driven high");
  a_cfg_off: assert property (hard_reset_line_oe_o |-> !cfg_pins_oe_o)
    else $error("straps driven in hard reset");
  a_cfg_back: assert property ($rose(cfg_pins_oe_o) |-> $past(hard_reset_line_n_i) &&
    $past(hard_reset_line_n_i, 2) && $past(hard_reset_line_n_i, 3))
    else $error("straps driven too early");
  a_hard_qual: assert property ($rose(hard_reset_line_oe_o) &&
    power_on_reset_in_n_i && !$past(sw_hard_req_i, 2) |-> plow_q >= 32 || plast_q >= 32)
    else $error("hard flow on short pulse");
  a_soft_qual: assert property ($rose(soft_reset_line_oe_o) &&
    !$rose(hard_reset_line_oe_o) |-> slow_q >= 32 || slast_q >= 32)
    else $error("soft flow on short pulse");
  a_latch_hold: assert property (core_hard_rst_n_o && $past(core_hard_rst_n_o)
    |-> $stable(cfg_latched_o)) else $error("straps resampled");
  a_core_order: assert property ($rose(core_soft_rst_n_o) |-> core_hard_rst_n_o)
    else $error("soft core reset first");
endmodule

bind rst_seq rst_seq_assertions u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .host_mode_i(host_mode_i), .power_on_reset_in_n_i(power_on_reset_in_n_i),
  .hard_reset_line_n_i(hard_reset_line_n_i), .sw_hard_req_i(sw_hard_req_i),
  .soft_reset_line_n_i(soft_reset_line_n_i), .hard_reset_line_o(hard_reset_line_o),
  .hard_reset_line_oe_o(hard_reset_line_oe_o), .soft_reset_line_o(soft_reset_line_o),
  .soft_reset_line_oe_o(soft_reset_line_oe_o), .cfg_pins_oe_o(cfg_pins_oe_o),
  .cfg_latched_o(cfg_latched_o), .core_hard_rst_n_o(core_hard_rst_n_o),
  .core_soft_rst_n_o(core_soft_rst_n_o));

// ==== verification/testbench.sv ====
// bench for the reset sequencer with the board model
// assumes inputs change at the falling edge only
`timescale 1ns/1ps
module testbench
  import rst_pkg::*;
;
  typedef struct packed {rst_cfg_t cfg; logic [10:0] len;} rst_note_t;
  logic        core_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        host_mode_i = 1'b0;
  logic        por_n = 1'b0;
  logic        hard_pull = 1'b0;
  logic        soft_pull = 1'b0;
  logic        sw_req = 1'b0;
  rst_cfg_t    strap = 4'h0;
  rst_cfg_t    drv_val = 4'h0;
  rst_cfg_t    cur = 4'h0;
  logic        hard_n, soft_n, hard_d, hard_oe, soft_d, soft_oe, cfg_oe, core_h, core_s;
  rst_cfg_t    cfg_in, cfg_out, latched;
  rst_note_t   note;
  rst_note_t   exp_q[$];
  int          fail_count = 0;
  int          total_checks = 0;
  int          hlen = 0;
  logic [31:0] rnd = 32'h0000003C;

  initial forever #12.5 core_clk_i = ~core_clk_i;

  rst_board_model board (.core_clk_i(core_clk_i), .hard_oe_i(hard_oe), .soft_oe_i(soft_oe),
    .hard_pull_i(hard_pull), .soft_pull_i(soft_pull), .strap_i(strap), .dut_cfg_i(cfg_out),
    .dut_cfg_oe_i(cfg_oe), .hard_n_o(hard_n), .soft_n_o(soft_n), .cfg_o(cfg_in));
  // internal hard request driven by one scenario of its own
  rst_seq DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .host_mode_i(host_mode_i),
    .power_on_reset_in_n_i(por_n), .hard_reset_line_n_i(hard_n),
    .soft_reset_line_n_i(soft_n), .sw_hard_req_i(sw_req), .cfg_pins_i(cfg_in),
    .cfg_drive_val_i(drv_val), .hard_reset_line_o(hard_d), .hard_reset_line_oe_o(hard_oe),
    .soft_reset_line_o(soft_d), .soft_reset_line_oe_o(soft_oe), .cfg_pins_o(cfg_out),
    .cfg_pins_oe_o(cfg_oe), .cfg_latched_o(latched), .core_hard_rst_n_o(core_h),
    .core_soft_rst_n_o(core_s));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // bounded wait for the run state, then strap redrive
  task automatic wait_run();
    int i;
    for (i = 0; i < 4000 && core_s !== 1'b1; i++) cyc(1);
    check({15'h0, core_s}, 16'h1, "release timeout");
    if (core_s !== 1'b1) conclude();
    cyc(4);
    check({15'h0, core_h}, 16'h1, "core hard release");
    check({14'h0, hard_d, soft_d}, 16'h0, "pin data");
    check({11'h0, cfg_oe, cfg_in}, {11'h0, 1'b1, drv_val}, "strap drive");
  endtask
  task automatic por_flow(input logic host);
    rnd = xs(rnd);
    strap = {rnd[3:1], host};
    drv_val = rnd[7:4];
    host_mode_i = host;
    por_n = 1'b0;
    cyc(40);
    cur = strap;
    exp_q.push_back({strap, host ? 11'd1024 : 11'd512});
    por_n = 1'b1;
    wait_run();
    $display("power-on flow done, host %0b", host);
  endtask
  task automatic pulse(input logic hard, input int n, input logic act);
    rnd = xs(rnd);
    strap = rnd[3:0];
    if (hard) hard_pull = 1'b1;
    else soft_pull = 1'b1;
    if (act && hard) exp_q.push_back({cur, 11'd512});
    cyc(n);
    hard_pull = 1'b0;
    soft_pull = 1'b0;
    cyc(4);
    check({15'h0, hard_oe | soft_oe}, {15'h0, act}, "flow start");
    if (act) wait_run();
    $display("pulse done, hard %0b length %0d", hard, n);
  endtask

  // monitor: each hard pull release is matched to the oldest note
  always @(negedge core_clk_i) begin
    if (hard_oe === 1'b1) hlen <= hlen + 1;
    else if (hlen != 0) begin
      if (exp_q.size() == 0) check(16'h0, 16'h1, "unexpected flow");
      else begin
        note = exp_q.pop_front();
        check({15'h0, hlen >= note.len}, 16'h1, "hard pull length");
        check({12'h0, latched}, {12'h0, note.cfg}, "sampled straps");
      end
      hlen <= 0;
    end
  end

  initial begin
    cyc(3);
    resetn_i = 1'b1;
    por_flow(1'b0);
    pulse(1'b1, 30, 1'b0);
    pulse(1'b1, 40, 1'b1);
    pulse(1'b0, 30, 1'b0);
    pulse(1'b0, 40, 1'b1);
    sw_req = 1'b1;
    exp_q.push_back({cur, 11'd512});
    cyc(1);
    sw_req = 1'b0;
    cyc(4);
    check({14'h0, hard_oe, cfg_oe}, 16'h2, "request flow start");
    wait_run();
    $display("request flow done");
    por_flow(1'b1);
    cyc(5);
    check(16'(exp_q.size()), 16'h0, "flow notes left");
    conclude();
  end
endmodule
